// >>> verilog/mrpu_top.sv
// Purpose: Memory request priority unit, picks and issues one request per minor cycle
// Assumes: Requesters are logic on clk_sys_i and hold a request until accepted
// Notes: All decisions are taken on the last clock of each 20 ns minor cycle
`timescale 1ns/1ps
module mrpu_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_req_i,
  input wire logic [`MRPU_BANK_W-1:0] scl_bank_i,
  input wire logic scl_write_i,
  input wire logic scl_ls_i,
  input wire logic scl_word_i,
  input wire logic vio_req_i,
  input wire logic [`MRPU_BANK_W-1:0] vio_bank_i,
  input wire logic vio_write_i,
  output logic scl_accept_o,
  output logic vio_accept_o,
  output logic buf_vld_o,
  output logic buf_write_o,
  output logic [`MRPU_QS_W-1:0] buf_qs_clks_o,
  output mrpu_pkg::mrpu_qty_t buf_qty_o,
  output logic [`MRPU_BANK_W-1:0] bank_addr_o,
  output logic strobe_o,
  output logic rd_buf_o,
  output logic [`MRPU_NSTK-1:0] stack_mask_o,
  output logic [`MRPU_NSTK-1:0] stack_busy_o
);
  import mrpu_pkg::*;

  typedef struct packed {
    logic [`MRPU_TICK_W-1:0] tick_cnt;
    logic scl_acc;
    logic vio_acc;
    logic buf_vld;
    logic buf_write;
    logic [`MRPU_QS_W-1:0] buf_qs;
    mrpu_qty_t buf_qty;
    logic [`MRPU_BANK_W-1:0] bank_addr;
    logic strobe;
    logic rd_buf;
    logic iss_vio;
    logic iss_write;
    mrpu_qty_t iss_qty;
    logic [`MRPU_BANK_W-1:0] iss_bank;
    logic [`MRPU_NSTK-1:0] stk_mask;
    logic [`MRPU_NSTK-1:0][`MRPU_BUSY_W-1:0] busy_cnt;
  } mrpu_state_t;

  mrpu_state_t st_r;
  mrpu_state_t st_nxt;
  mrpu_hist_if hist_if ();

  mrpu_history u_history (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .hist_if(hist_if)
  );

  function automatic logic same_sword(input logic [`MRPU_BANK_W-1:0] a,
                                      input logic [`MRPU_BANK_W-1:0] b);
    return a[`MRPU_BANK_W-1:`MRPU_SWORD_LSB] == b[`MRPU_BANK_W-1:`MRPU_SWORD_LSB];
  endfunction : same_sword

  // Stacks touched by a transfer of the given quantity
  function automatic logic [`MRPU_NSTK-1:0] stk_mask(input logic [`MRPU_BANK_W-1:0] bank,
                                                     input mrpu_qty_t qty);
    logic [`MRPU_NSTK-1:0] m;
    m = `MRPU_HALF_STK << bank[`MRPU_SWORD_LSB-1:0];
    if (qty == QTY_SWORD) begin
      m = `MRPU_ALL_STK;
    end else if (qty == QTY_WORD) begin
      m = `MRPU_WORD_STK << {bank[`MRPU_SWORD_LSB-1:1], 1'b0};
    end
    return m;
  endfunction : stk_mask

  // Banks overlap when the larger quantity's stacks intersect
  function automatic logic overlap(input logic [`MRPU_BANK_W-1:0] a, input mrpu_qty_t qa,
                                   input logic [`MRPU_BANK_W-1:0] b, input mrpu_qty_t qb);
    mrpu_qty_t big;
    big = (qa > qb) ? qa : qb;
    return same_sword(a, b) && ((stk_mask(a, big) & stk_mask(b, big)) != '0);
  endfunction : overlap

  logic tick;
  logic vio_ok;
  logic scl_ok;
  mrpu_qty_t scl_qty;
  logic [`MRPU_DLY_W-1:0] scl_dly;
  mrpu_ent_t new_ent;
  mrpu_ent_t iss_ent;
  mrpu_ent_t pre_ent;
  mrpu_ent_t e;

  assign tick = st_r.tick_cnt == `MRPU_TICK_W'(`MRPU_MINOR_CLKS - 1);

  assign scl_qty = !scl_ls_i ? QTY_SWORD : (scl_word_i ? QTY_WORD : QTY_HALF);

  assign scl_dly = (scl_write_i && scl_qty == QTY_SWORD) ?
                   `MRPU_SCL_DLY + `MRPU_SCL_SWW_EXTRA : `MRPU_SCL_DLY;

  always_comb begin
    vio_ok = vio_req_i;
    scl_ok = scl_req_i && !vio_req_i;
    iss_ent = '0;
    pre_ent = '0;
    e = '0;
    for (int k = 1; k <= `MRPU_HIST_DEPTH; k++) begin
      e = hist_if.hist[k-1];
      if (e.valid) begin
        if (e.vio && k <= `MRPU_VIO_REP_WIN && same_sword(e.bank, vio_bank_i)) begin
          vio_ok = 1'b0;
        end
        // vector arrivals 10 to 12 back
        if (e.vio && k >= `MRPU_VIO_FAR_LO && k <= `MRPU_VIO_FAR_HI &&
            same_sword(e.bank, scl_bank_i)) begin
          scl_ok = 1'b0;
        end
        // address bus taken by vector issue
        if (e.vio && k == `MRPU_VIO_BUS_AGE) begin
          scl_ok = 1'b0;
        end
        // vector arrivals 6 to 8 back
        if (e.vio && k >= `MRPU_VIO_NEAR_LO && k <= `MRPU_VIO_NEAR_HI &&
            same_sword(e.bank, scl_bank_i)) begin
          scl_ok = 1'b0;
        end
        if (!e.vio && k <= `MRPU_SCL_REP_WIN && overlap(e.bank, e.qty, scl_bank_i, scl_qty)) begin
          scl_ok = 1'b0;
        end
        // Keep issue slots unique on the single address path
        if (int'(e.delay) - k == int'(scl_dly)) begin
          scl_ok = 1'b0;
        end
        // issue when delay is used up
        if (int'(e.delay) == k) begin
          iss_ent = e;
        end
        if (int'(e.delay) == k + 1) begin
          pre_ent = e;
        end
      end
    end
  end

  always_comb begin
    new_ent = '0;
    if (vio_ok) begin
      new_ent.valid = 1'b1;
      new_ent.vio = 1'b1;
      new_ent.write = vio_write_i;
      new_ent.qty = QTY_SWORD;
      new_ent.bank = vio_bank_i;
      new_ent.delay = `MRPU_VIO_DLY;
    end else if (scl_ok) begin
      new_ent.valid = 1'b1;
      new_ent.write = scl_write_i;
      new_ent.qty = scl_qty;
      new_ent.bank = scl_bank_i;
      new_ent.delay = scl_dly;
    end
  end

  // every minor cycle pushes one slot
  assign hist_if.push = tick;
  assign hist_if.ent = new_ent;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick_cnt = st_r.tick_cnt + `MRPU_TICK_W'(1);
    st_nxt.scl_acc = 1'b0;
    st_nxt.vio_acc = 1'b0;
    st_nxt.buf_vld = 1'b0;
    if (tick) begin
      st_nxt.vio_acc = new_ent.valid && new_ent.vio;
      st_nxt.scl_acc = new_ent.valid && !new_ent.vio;
      if (new_ent.valid) begin
        st_nxt.buf_vld = 1'b1;
        st_nxt.buf_write = new_ent.write;
        st_nxt.buf_qty = new_ent.qty;
        // vector rate 40 ns per quarter
        // scalar rate 20 ns per quarter
        st_nxt.buf_qs = new_ent.vio ? `MRPU_QS_W'(`MRPU_VIO_QS_NS / `MRPU_CLK_NS) :
                                      `MRPU_QS_W'(`MRPU_SCL_QS_NS / `MRPU_CLK_NS);
      end
      if (pre_ent.valid) begin
        st_nxt.bank_addr = pre_ent.bank;
      end
      // strobe and read control at issue
      st_nxt.strobe = iss_ent.valid;
      st_nxt.rd_buf = iss_ent.valid && !iss_ent.write;
      st_nxt.iss_vio = iss_ent.vio;
      st_nxt.iss_write = iss_ent.write;
      st_nxt.iss_qty = iss_ent.qty;
      st_nxt.iss_bank = iss_ent.bank;
      st_nxt.stk_mask = iss_ent.valid ? stk_mask(iss_ent.bank, iss_ent.qty) : '0;
      for (int s = 0; s < `MRPU_NSTK; s++) begin
        if (iss_ent.valid && st_nxt.stk_mask[s]) begin
          st_nxt.busy_cnt[s] = `MRPU_BUSY_MC;
        end else if (st_r.busy_cnt[s] != '0) begin
          st_nxt.busy_cnt[s] = st_r.busy_cnt[s] - `MRPU_BUSY_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign scl_accept_o = st_r.scl_acc;
  assign vio_accept_o = st_r.vio_acc;
  assign buf_vld_o = st_r.buf_vld;
  assign buf_write_o = st_r.buf_write;
  assign buf_qs_clks_o = st_r.buf_qs;
  assign buf_qty_o = st_r.buf_qty;
  assign bank_addr_o = st_r.bank_addr;
  assign strobe_o = st_r.strobe;
  assign rd_buf_o = st_r.rd_buf;
  assign stack_mask_o = st_r.stk_mask;

  always_comb begin
    for (int s = 0; s < `MRPU_NSTK; s++) begin
      stack_busy_o[s] = st_r.busy_cnt[s] != '0;
    end
  end

  localparam int VioLat = int'(`MRPU_VIO_DLY) * `MRPU_MINOR_CLKS;
  localparam int SclLat = int'(`MRPU_SCL_DLY) * `MRPU_MINOR_CLKS;
  localparam int SwwLat = int'(`MRPU_SCL_DLY + `MRPU_SCL_SWW_EXTRA) * `MRPU_MINOR_CLKS;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence tick_gap_s;
    !tick [*3] ##1 tick;
  endsequence

  AST_TICK_PERIOD: assert property (tick |=> tick_gap_s)
    else $error("minor cycle tick not every four clocks");

  AST_ONE_WINNER: assert property (!(scl_accept_o && vio_accept_o))
    else $error("two requests accepted in one minor cycle");

  AST_VIO_STROBE: assert property (vio_accept_o |-> ##VioLat (strobe_o && st_r.iss_vio))
    else $error("vector strobe not nine minor cycles after accept");

  AST_SCL_STROBE: assert property (scl_accept_o && !(buf_write_o && buf_qty_o == QTY_SWORD)
      |-> ##SclLat (strobe_o && !st_r.iss_vio))
    else $error("scalar strobe not two minor cycles after accept");

  AST_SWW_STROBE: assert property (scl_accept_o && buf_write_o && buf_qty_o == QTY_SWORD
      |-> !strobe_o [*1] ##SwwLat strobe_o)
    else $error("scalar sword write strobe not five minor cycles after accept");

  AST_STK_COUNT: assert property (strobe_o |-> $countones(stack_mask_o) ==
      ((st_r.iss_qty == QTY_SWORD) ? 16 : (st_r.iss_qty == QTY_WORD) ? 2 : 1))
    else $error("stack mask width does not match quantity");

  // busy only starts with a strobe
  AST_BUSY_START: assert property ($rose(|stack_busy_o) |-> strobe_o
      && ((stack_busy_o & stack_mask_o) == stack_mask_o))
    else $error("bank busy started without an issue");

  AST_BANK_EARLY: assert property ($rose(strobe_o) |-> $past(bank_addr_o, 4) == st_r.iss_bank)
    else $error("bank address not presented before issue");

  AST_BUF_CTRL: assert property ((scl_accept_o || vio_accept_o) |-> buf_vld_o &&
      (buf_qs_clks_o == (vio_accept_o ? 4'h8 : 4'h4)))
    else $error("buffer controls missing or wrong rate at accept");

  AST_RDBUF: assert property (rd_buf_o |-> strobe_o && !st_r.iss_write)
    else $error("read buffer control outside a read issue");
endmodule : mrpu_top

// >>> pkg/mrpu_defs.svh
// Purpose: Named constants for the memory request priority unit
// Assumes: 200 MHz system clock, 20 ns minor cycle
// Notes: Delays and windows are in minor cycles
`ifndef MRPU_DEFS_SVH
`define MRPU_DEFS_SVH

`define MRPU_CLK_NS 5
`define MRPU_MINOR_NS 20
`define MRPU_MINOR_CLKS (`MRPU_MINOR_NS / `MRPU_CLK_NS)
`define MRPU_TICK_W 2
`define MRPU_BANK_W 9
`define MRPU_SWORD_LSB 4
`define MRPU_NSTK 16
`define MRPU_HIST_DEPTH 12
`define MRPU_DLY_W 4
`define MRPU_VIO_DLY 4'h9
`define MRPU_SCL_DLY 4'h2
`define MRPU_SCL_SWW_EXTRA 4'h3
`define MRPU_BUSY_W 3
`define MRPU_BUSY_MC 3'h4
`define MRPU_VIO_REP_WIN 3
`define MRPU_SCL_REP_WIN 3
`define MRPU_VIO_FAR_LO 10
`define MRPU_VIO_FAR_HI 12
`define MRPU_VIO_BUS_AGE 9
`define MRPU_VIO_NEAR_LO 6
`define MRPU_VIO_NEAR_HI 8
`define MRPU_VIO_QS_NS 40
`define MRPU_SCL_QS_NS 20
`define MRPU_QS_W 4
`define MRPU_ALL_STK 16'hFFFF
`define MRPU_WORD_STK 16'h0003
`define MRPU_HALF_STK 16'h0001

`endif

// >>> pkg/mrpu_pkg.sv
// Purpose: Types shared by the priority unit modules
// Assumes: Constants come from mrpu_defs.svh
// Notes: Quantity order matters, larger quantity compares greater
`include "mrpu_defs.svh"
package mrpu_pkg;
  typedef enum logic [1:0] {QTY_HALF, QTY_WORD, QTY_SWORD} mrpu_qty_t;

  typedef struct packed {
    logic valid;
    logic vio;
    logic write;
    mrpu_qty_t qty;
    logic [`MRPU_BANK_W-1:0] bank;
    logic [`MRPU_DLY_W-1:0] delay;
  } mrpu_ent_t;

  typedef mrpu_ent_t [`MRPU_HIST_DEPTH-1:0] mrpu_hist_t;
endpackage : mrpu_pkg

// >>> pkg/mrpu_hist_if.sv
// Purpose: Carries honored requests into the history store and back
// Assumes: One push per minor cycle
// Notes: Slot k holds the request honored k+1 minor cycles ago
`timescale 1ns/1ps
interface mrpu_hist_if;
  import mrpu_pkg::*;
  logic push;
  mrpu_ent_t ent;
  mrpu_hist_t hist;
  modport owner (output push, output ent, input hist);
  modport store (input push, input ent, output hist);
endinterface : mrpu_hist_if

// >>> verilog/mrpu_history.sv
// Purpose: Shift history of honored requests, one slot per minor cycle
// Assumes: push pulses once per minor cycle
// Notes: Empty cycles push an invalid entry
`timescale 1ns/1ps
module mrpu_history (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  mrpu_hist_if.store hist_if
);
  import mrpu_pkg::*;

  typedef struct packed {
    mrpu_hist_t slot;
  } mrpu_hstate_t;

  mrpu_hstate_t st_r;
  mrpu_hstate_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (hist_if.push) begin
      st_nxt.slot = {st_r.slot[`MRPU_HIST_DEPTH-2:0], hist_if.ent};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hist_if.hist = st_r.slot;
endmodule : mrpu_history

// >>> verification/mrpu_req_model.sv
// Purpose: Requester model for one request port of the priority unit
// Assumes: Driven off the falling edge, design samples on rising edges
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
module mrpu_req_model (
  input wire logic clk_sys_i,
  input wire logic accept_i,
  output logic req_o,
  output logic [8:0] bank_o,
  output logic write_o,
  output logic ls_o,
  output logic word_o
);
  int cyc = 0;
  int acc_cyc = 0;
  initial begin
    req_o = 1'h0;
    bank_o = 9'h000;
    write_o = 1'h0;
    ls_o = 1'h0;
    word_o = 1'h0;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
  end
  task automatic send(input logic [8:0] b, input logic w, input logic l, input logic d);
    int n;
    @(negedge clk_sys_i);
    req_o = 1'h1;
    bank_o = b;
    write_o = w;
    ls_o = l;
    word_o = d;
    acc_cyc = -1;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_sys_i);
      if (accept_i === 1'h1) begin
        acc_cyc = cyc;
        break;
      end
    end
    req_o = 1'h0;
    bank_o = ~b;
    write_o = ~w;
    ls_o = ~l;
    word_o = ~d;
  endtask : send
endmodule : mrpu_req_model

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the memory request priority unit
// Assumes: Kind code is {vector, write, load/store, word}
// Notes: Gaps and delays are counted in system clocks
`timescale 1ns/1ps
module tb_top;
  import mrpu_pkg::*;
  typedef struct packed {logic [3:0] k; logic [8:0] bank;} mrpu_rq_t;
  typedef struct packed {mrpu_rq_t r; int dly; logic [15:0] mask;} mrpu_row_t;
  typedef struct packed {mrpu_rq_t a; mrpu_rq_t b; int dly; int gap;} mrpu_pair_t;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic scl_req, scl_write, scl_ls, scl_word, vio_req, vio_write;
  logic [8:0] scl_bank, vio_bank, bank_addr, bank_p1, bank_p2, bank_p3;
  logic scl_acc, vio_acc, buf_vld, buf_write, strobe, rd_buf;
  logic [3:0] buf_qs;
  mrpu_qty_t buf_qty;
  logic [15:0] stack_mask, stack_busy;
  int cycles = 0;
  int bad_count = 0;
  int n_compared = 0;
  mrpu_row_t rows [7] = '{'{'{4'h8, 9'h025}, 36, 16'hFFFF}, '{'{4'hC, 9'h130}, 36, 16'hFFFF},
    '{'{4'h0, 9'h040}, 8, 16'hFFFF}, '{'{4'h4, 9'h041}, 20, 16'hFFFF},
    '{'{4'h3, 9'h057}, 8, 16'h00C0}, '{'{4'h6, 9'h05B}, 8, 16'h0800},
    '{'{4'h7, 9'h0A3}, 8, 16'h000C}};
  mrpu_pair_t pairs [9] = '{'{'{4'h8, 9'h020}, '{4'h8, 9'h02F}, 0, 16},
    '{'{4'h8, 9'h020}, '{4'h8, 9'h030}, 0, 4}, '{'{4'h8, 9'h020}, '{4'h0, 9'h030}, 32, 40},
    '{'{4'h8, 9'h020}, '{4'h2, 9'h025}, 20, 52}, '{'{4'h8, 9'h020}, '{4'h2, 9'h035}, 20, 24},
    '{'{4'h2, 9'h040}, '{4'h3, 9'h041}, 0, 16}, '{'{4'h2, 9'h040}, '{4'h2, 9'h041}, 0, 4},
    '{'{4'h0, 9'h040}, '{4'h2, 9'h04F}, 0, 16}, '{'{4'h4, 9'h040}, '{4'h2, 9'h050}, 8, 16}};

  mrpu_top mrpu_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_req_i(scl_req),
    .scl_bank_i(scl_bank), .scl_write_i(scl_write), .scl_ls_i(scl_ls), .scl_word_i(scl_word),
    .vio_req_i(vio_req), .vio_bank_i(vio_bank), .vio_write_i(vio_write),
    .scl_accept_o(scl_acc), .vio_accept_o(vio_acc), .buf_vld_o(buf_vld),
    .buf_write_o(buf_write), .buf_qs_clks_o(buf_qs), .buf_qty_o(buf_qty),
    .bank_addr_o(bank_addr), .strobe_o(strobe), .rd_buf_o(rd_buf),
    .stack_mask_o(stack_mask), .stack_busy_o(stack_busy));
  mrpu_req_model scl_model_inst (.clk_sys_i(clk_sys_i), .accept_i(scl_acc), .req_o(scl_req),
    .bank_o(scl_bank), .write_o(scl_write), .ls_o(scl_ls), .word_o(scl_word));
  mrpu_req_model vio_model_inst (.clk_sys_i(clk_sys_i), .accept_i(vio_acc), .req_o(vio_req),
    .bank_o(vio_bank), .write_o(vio_write), .ls_o(), .word_o());

  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      stop_test();
    end
  end
  always @(negedge clk_sys_i) begin
    bank_p1 <= bank_addr;
    bank_p2 <= bank_p1;
    bank_p3 <= bank_p2;
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'h1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic send_rq(input mrpu_rq_t q, output int acc);
    if (q.k[3]) begin
      vio_model_inst.send(q.bank, q.k[2], 1'h0, 1'h0);
      acc = vio_model_inst.acc_cyc;
    end else begin
      scl_model_inst.send(q.bank, q.k[2], q.k[1], q.k[0]);
      acc = scl_model_inst.acc_cyc;
    end
  endtask : send_rq
  task automatic run_row(input mrpu_row_t e);
    int acc;
    int k;
    mrpu_qty_t q;
    send_rq(e.r, acc);
    q = (e.r.k[3] || !e.r.k[1]) ? QTY_SWORD : (e.r.k[0] ? QTY_WORD : QTY_HALF);
    chk(buf_vld === 1'h1 && buf_write === e.r.k[2], "buffer controls");
    chk(buf_qty === q, "quantity");
    chk(buf_qs === (e.r.k[3] ? 4'h8 : 4'h4), "rate");
    for (k = 0; k < 80 && strobe !== 1'h1; k++) @(negedge clk_sys_i);
    chk(cycles - acc == e.dly, "strobe delay");
    chk(stack_mask === e.mask, "stack mask");
    chk(bank_addr === e.r.bank && bank_p3 === e.r.bank, "bank address");
    chk(rd_buf === ~e.r.k[2], "read control");
    for (k = 1; k <= 16; k++) begin
      @(negedge clk_sys_i);
      if (k == 3 || k == 4) chk(strobe === (k == 3), "strobe width");
      if (k == 15 || k == 16) chk(stack_busy === (k == 15 ? e.mask : 16'h0000), "busy");
    end
    repeat (60) @(negedge clk_sys_i);
  endtask : run_row
  task automatic run_pair(input mrpu_pair_t p);
    int a0;
    int a1;
    send_rq(p.a, a0);
    repeat (p.dly) @(negedge clk_sys_i);
    send_rq(p.b, a1);
    chk(a1 - a0 == p.gap, "accept gap");
    repeat (80) @(negedge clk_sys_i);
  endtask : run_pair

  initial begin
    int i;
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1'h1;
    for (i = 0; i < 7; i++) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    for (i = 0; i < 9; i++) begin
      run_pair(pairs[i]);
      $display("pair %0d done", i);
    end
    fork
      vio_model_inst.send(9'h020, 1'h0, 1'h0, 1'h0);
      scl_model_inst.send(9'h060, 1'h0, 1'h0, 1'h0);
    join
    chk(scl_model_inst.acc_cyc - vio_model_inst.acc_cyc == 4, "priority");
    $display("priority done");
    repeat (80) @(negedge clk_sys_i);
    scl_model_inst.send(9'h070, 1'h0, 1'h0, 1'h0);
    repeat (9) @(negedge clk_sys_i);
    rst_n_i = 1'h0;
    #1;
    chk(strobe === 1'h0 && stack_busy === 16'h0000 && bank_addr === 9'h000, "reset");
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1'h1;
    run_row(rows[2]);
    $display("reset done");
    stop_test();
  end
endmodule : tb_top
